// file: flat_priority_interrupt_ctrl_test.sv
// Self-checking bench for the interrupt controller.
// Assumes inputs change on the falling edge; core model gives strobes.
`timescale 1ns/1ps
module flat_priority_interrupt_ctrl_test;
	logic clk = 0, rst = 1, men = 0;
	logic [7:0] p0 = 0, mwd = 0, ewd = 0, mask, em = 0;
	logic [3:0] p1 = 0, lat = 0;
	logic cwr = 0, mwr = 0, vwr = 0, elw = 0, ehw = 0, flw = 0, fhw = 0;
	logic [15:0] cwd = 0, vwd = 0, vec, mvec, ev = 0;
	logic [15:0] p [12] = '{default: 16'h0000};
	logic taken, ret, req, gen, in_service_bit, eg = 0, ei = 0;
	logic [11:0] een, efl, eee = 0, eef = 0;
	int failures = 0, n_compared = 0;
	always #2 clk = ~clk;

	fpic_top dut_u (.I_CLK(clk), .I_RST(rst), .I_PORT0_PINS(p0),
		.I_PORT1_PINS(p1), .I_CONTROL_WR(cwr), .I_CONTROL_WDATA(cwd),
		.I_MODULE_MASK_WR(mwr), .I_MODULE_MASK_WDATA(mwd),
		.I_VECTOR_WR(vwr), .I_VECTOR_WDATA(vwd),
		.I_EXT_ENABLE_LOW_WR(elw), .I_EXT_ENABLE_HIGH_WR(ehw),
		.I_EXT_FLAG_LOW_WR(flw), .I_EXT_FLAG_HIGH_WR(fhw),
		.I_EXT_WDATA(ewd), .I_SUPPLY_MONITOR_REG(p[0]),
		.I_SERIAL_MODE_REG(p[1]), .I_SERIAL_CONTROL_REG(p[2]),
		.I_SPI_CONFIG_REG(p[3]), .I_SPI_CONTROL_REG(p[4]),
		.I_TWOWIRE_STATUS_REG(p[5]), .I_TWOWIRE_IRQ_ENABLE_REG(p[6]),
		.I_TIMER_B_CONTROL_REG(p[7]), .I_CONVERTER_CONTROL_REG(p[8]),
		.I_CONVERTER_STATUS_REG(p[9]), .I_AMPLIFIER_CONTROL_REG(p[10]),
		.I_WATCHDOG_CONTROL_REG(p[11]), .I_VECTOR_TAKEN(taken),
		.I_IRQ_RETURN(ret), .O_IRQ_REQ(req), .O_HANDLER_VECTOR(vec),
		.O_GLOBAL_ENABLE(gen), .O_IN_SERVICE(in_service_bit), .O_MODULE_MASK(mask),
		.O_EXT_ENABLES(een), .O_EXT_FLAGS(efl));
	fpic_core_model core_u (.i_clk(clk), .i_rst(rst), .i_en(men),
		.i_lat(lat), .i_req(req), .i_vec(vec), .o_taken(taken),
		.o_ret(ret), .o_vec(mvec));

	function automatic logic exp_req();
		logic r;
		r = em[7] & p[11][6] & p[11][3];
		r |= em[0] & (|(eee & eef) | (p[0][2] & p[0][3]));
		r |= em[1] & ((p[1][2] & |p[2][1:0]) | (p[3][7] & |p[4][6:3]));
		r |= em[1] & |(p[5][11:0] & p[6][11:0] & 12'hBFF);
		r |= em[2] & p[7][1] & |p[7][7:6];
		r |= em[3] & ((p[8][5] & p[9][5]) | (p[10][4] & p[10][5]));
		return eg & ~ei & r;
	endfunction

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
		n_compared++;
		if (seen !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
		end
	endtask

	// Write strobe for one cycle; entered and left on a falling edge
	task wr(input int k, input logic [15:0] d);
		case (k)
			0: {cwr, cwd, eg, ei} = {1'b1, d, d[0], d[1]};
			1: {mwr, mwd, em} = {1'b1, d[7:0], d[7:0]};
			2: {vwr, vwd, ev} = {1'b1, d, d};
			3: {elw, ewd, eee[7:0]} = {1'b1, d[7:0], d[7:0]};
			4: {ehw, ewd, eee[11:8]} = {1'b1, d[7:0], d[3:0]};
			5: {flw, ewd, eef[7:0]} = {1'b1, d[7:0], d[7:0]};
			default: {fhw, ewd, eef[11:8]} = {1'b1, d[7:0], d[3:0]};
		endcase
		@(negedge clk);
		// Only the strobe raised above is dropped, so none is set twice
		case (k)
			0: cwr = 1'b0;
			1: mwr = 1'b0;
			2: vwr = 1'b0;
			3: elw = 1'b0;
			4: ehw = 1'b0;
			5: flw = 1'b0;
			default: fhw = 1'b0;
		endcase
	endtask

	task state(input string t);
		chk("irq_req", req, exp_req());
		chk("global", gen, eg);
		chk("in_service", in_service_bit, ei);
		chk("module_mask", mask, em);
		chk("ext_en", een, eee);
		chk("ext_flag", efl, eef);
		chk("vector", vec, ev);
		$display("test %s done", t);
	endtask

	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Longest run is a few thousand cycles; this limit is ample
	initial
	begin
		#60000;
		failures++;
		tally_and_finish;
	end

	initial
	begin
		void'($urandom(65));
		repeat (3) @(negedge clk);
		rst = 0;
		@(negedge clk);
		state("reset");
		// Sparse random sources cover every gate and module bit
		repeat (300)
		begin
			for (int k = 0; k < 7; k++)
				wr(k, $urandom & (k > 4 ? $urandom & $urandom : '1));
			foreach (p[j])
				p[j] = $urandom & $urandom & $urandom;
			@(negedge clk);
			chk("random_req", req, exp_req());
		end
		state("random");
		p = '{default: 16'h0000};
		p[5] = 16'h0400;
		p[6] = 16'h0400;
		wr(0, 16'h0001);
		wr(1, 16'h00FF);
		for (int k = 3; k < 7; k++)
			wr(k, k < 5 ? 16'h00FF : 16'h0000);
		@(negedge clk);
		state("unused two-wire bit");
		{p1, p0} = 12'h9A5;
		repeat (2) @(negedge clk);
		// Clear lands with the edge event; the event must survive
		wr(5, 16'h0000);
		eef = 12'h9A5;
		{p0, p1} = 12'h000;
		repeat (2) @(negedge clk);
		state("pin events");
		wr(5, 16'h0000);
		wr(6, 16'h0000);
		@(negedge clk);
		state("software clear");
		for (int t = 0; t < 2; t++)
		begin
			wr(2, $urandom);
			wr(5, 16'h0001);
			lat <= t ? 4'h5 : 4'h0;
			men <= 1;
			for (int n = 0; n < 40 && in_service_bit !== 1'b1; n++)
				@(negedge clk);
			chk("req_after_take", req, 1'b0);
			chk("core_vector", mvec, ev);
			for (int n = 0; n < 40 && in_service_bit !== 1'b0; n++)
				@(negedge clk);
			men <= 0;
			@(negedge clk);
			chk("req_after_return", req, 1'b1);
			wr(5, 16'h0000);
			@(negedge clk);
			state("vector and return");
		end
		tally_and_finish;
	end
endmodule

// file: fpic_core_model.sv
// Core sequencer model: takes the vector, later returns from handler.
// Assumes strobes are sampled by the controller on the rising edge.
`timescale 1ns/1ps
module fpic_core_model (
	// Clock, reset and control
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_en,
	input wire logic [3:0] i_lat,
	// Controller side
	input wire logic i_req,
	input wire logic [15:0] i_vec,
	output logic o_taken,
	output logic o_ret,
	output logic [15:0] o_vec
);
	int cnt;
	logic busy;
	// Driven on the falling edge so strobes are stable at the rising edge
	always @(negedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			{o_taken, o_ret, busy, cnt, o_vec} <= '0;
		end
		else
		begin
			o_taken <= 1'b0;
			o_ret <= 1'b0;
			cnt <= cnt + 1;
			if (!busy && !(i_en && i_req))
				cnt <= 0;
			else if (!busy && cnt >= i_lat)
			begin
				o_taken <= 1'b1;
				o_vec <= i_vec;
				busy <= 1'b1;
				cnt <= 0;
			end
			else if (busy && cnt >= i_lat)
			begin
				o_ret <= 1'b1;
				busy <= 1'b0;
				cnt <= 0;
			end
		end
	end
endmodule

// file: fpic_ext_flags.sv
// External interrupt flags: pin synchroniser, edge detect, flag store.
// Assumes pins are asynchronous; rising edge marks an event.
`timescale 1ns/1ps
module fpic_ext_flags #(
	parameter int W = 12
) (
	input wire logic i_clk,
	input wire logic i_rst,
	fpic_ext_if.owner ext
);

	logic [W-1:0] sync1_r;
	logic [W-1:0] sync2_r;
	logic [W-1:0] prev_r;
	logic [W-1:0] flags_r;
	logic [W-1:0] hw_set;
	logic [W-1:0] flags_nxt;

	// First stage feeds only the second
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end
		else
		begin
			sync1_r <= ext.pins;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	assign hw_set = sync2_r & ~prev_r;

	// Hardware only sets; a write in the same cycle cannot lose the event
	always_comb
	begin
		flags_nxt = (ext.wr_sel & ext.wr_data) | (~ext.wr_sel & flags_r);
		flags_nxt = flags_nxt | hw_set;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			flags_r <= '0;
		else
			flags_r <= flags_nxt;
	end

	assign ext.flags = flags_r;

	a_edge_sets_flag: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(|hw_set) |=> ((flags_r & $past(hw_set)) == $past(hw_set)))
		else $error("pin edge did not set its flag");

	a_flag_only_sw_clear: assert property (
		@(posedge i_clk) disable iff (i_rst)
		##1 ((($past(flags_r) & ~flags_r)
			& ~($past(ext.wr_sel) & ~$past(ext.wr_data))) == '0))
		else $error("flag cleared without software write");

endmodule

// file: fpic_ext_if.sv
// Link between the controller core and its external flag holder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fpic_ext_if #(parameter int W = 12);
	logic [W-1:0] pins;
	logic [W-1:0] wr_sel;
	logic [W-1:0] wr_data;
	logic [W-1:0] flags;

	modport owner (input pins, input wr_sel, input wr_data, output flags);
	modport user (output pins, output wr_sel, output wr_data, input flags);
endinterface

// file: fpic_pkg.sv
// Constants for the flat priority interrupt controller.
// Assumes a 16-bit core and peripheral registers on the same clock.
package fpic_pkg;

	// Handler vector and control reset values
	localparam logic [15:0] VECTOR_RESET = 16'h0000;
	localparam logic GLOBAL_EN_RESET = 1'h0;
	localparam logic IN_SERVICE_RESET = 1'h0;
	localparam logic [7:0] MODULE_MASK_RESET = 8'h00;

	// Control register fields
	localparam int CTRL_GLOBAL_EN_BIT = 0;
	localparam int CTRL_IN_SERVICE_BIT = 1;

	// Module mask register fields
	localparam int MASK_MOD0_BIT = 0;
	localparam int MASK_MOD1_BIT = 1;
	localparam int MASK_MOD2_BIT = 2;
	localparam int MASK_MOD3_BIT = 3;
	localparam int MASK_SYSTEM_BIT = 7;

	// External sources, port 0 then port 1
	localparam int EXT_LOW_W = 8;
	localparam int EXT_HIGH_W = 4;
	localparam int EXT_W = 12;
	localparam logic [11:0] EXT_RESET = 12'h000;

	// Supply monitor register fields
	localparam int SUPPLY_EN_BIT = 2;
	localparam int SUPPLY_FLAG_BIT = 3;

	// Serial port fields
	localparam int SERIAL_EN_BIT = 2;
	localparam int SERIAL_RX_BIT = 0;
	localparam int SERIAL_TX_BIT = 1;

	// SPI fields: four flags in one contiguous field
	localparam int SPI_EN_BIT = 7;
	localparam int SPI_FLAG_LO = 3;
	localparam int SPI_FLAG_HI = 6;

	// Two-wire sources: bits 0..9 and 11, bit 10 has no source
	localparam logic [11:0] TW_SOURCE_MASK = 12'hBFF;

	// Timer B fields
	localparam int TB_EN_BIT = 1;
	localparam int TB_TRIG_BIT = 6;
	localparam int TB_OVF_BIT = 7;

	// Converter, amplifier and watchdog fields
	localparam int CONV_EN_BIT = 5;
	localparam int CONV_FLAG_BIT = 5;
	localparam int AMP_EN_BIT = 4;
	localparam int AMP_FLAG_BIT = 5;
	localparam int WD_EN_BIT = 6;
	localparam int WD_FLAG_BIT = 3;

endpackage

// file: fpic_top.sv
// Flat priority interrupt controller: gating, in-service and vector.
// Assumes peripheral registers and core strobes share I_CLK.
`timescale 1ns/1ps
module fpic_top (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// External interrupt pins
	input wire logic [7:0] I_PORT0_PINS,
	input wire logic [3:0] I_PORT1_PINS,
	// Software writes to control state
	input wire logic I_CONTROL_WR,
	input wire logic [15:0] I_CONTROL_WDATA,
	input wire logic I_MODULE_MASK_WR,
	input wire logic [7:0] I_MODULE_MASK_WDATA,
	input wire logic I_VECTOR_WR,
	input wire logic [15:0] I_VECTOR_WDATA,
	input wire logic I_EXT_ENABLE_LOW_WR,
	input wire logic I_EXT_ENABLE_HIGH_WR,
	input wire logic I_EXT_FLAG_LOW_WR,
	input wire logic I_EXT_FLAG_HIGH_WR,
	input wire logic [7:0] I_EXT_WDATA,
	// Peripheral registers holding local enables and flags
	input wire logic [15:0] I_SUPPLY_MONITOR_REG,
	input wire logic [15:0] I_SERIAL_MODE_REG,
	input wire logic [15:0] I_SERIAL_CONTROL_REG,
	input wire logic [15:0] I_SPI_CONFIG_REG,
	input wire logic [15:0] I_SPI_CONTROL_REG,
	input wire logic [15:0] I_TWOWIRE_STATUS_REG,
	input wire logic [15:0] I_TWOWIRE_IRQ_ENABLE_REG,
	input wire logic [15:0] I_TIMER_B_CONTROL_REG,
	input wire logic [15:0] I_CONVERTER_CONTROL_REG,
	input wire logic [15:0] I_CONVERTER_STATUS_REG,
	input wire logic [15:0] I_AMPLIFIER_CONTROL_REG,
	input wire logic [15:0] I_WATCHDOG_CONTROL_REG,
	// Core sequencer strobes
	input wire logic I_VECTOR_TAKEN,
	input wire logic I_IRQ_RETURN,
	// Request and vector to the core
	output logic O_IRQ_REQ,
	output logic [15:0] O_HANDLER_VECTOR,
	// Control state readback
	output logic O_GLOBAL_ENABLE,
	output logic O_IN_SERVICE,
	output logic [7:0] O_MODULE_MASK,
	output logic [11:0] O_EXT_ENABLES,
	output logic [11:0] O_EXT_FLAGS
);

	logic global_irq_enable_r;
	logic in_service_bit_r;
	logic [7:0] module_mask_reg_r;
	logic [15:0] handler_vector_reg_r;
	logic [11:0] ext_enable_r;
	logic irq_req_r;
	logic pending;
	logic [3:0] group_hit;
	logic system_hit;
	logic [11:0] ext_flags;

	fpic_ext_if #(.W(fpic_pkg::EXT_W)) ext_link ();

	// Software writes reach flags per byte register
	assign ext_link.pins = {I_PORT1_PINS, I_PORT0_PINS};
	assign ext_link.wr_sel = {{fpic_pkg::EXT_HIGH_W{I_EXT_FLAG_HIGH_WR}},
		{fpic_pkg::EXT_LOW_W{I_EXT_FLAG_LOW_WR}}};
	assign ext_link.wr_data = {I_EXT_WDATA[3:0], I_EXT_WDATA};
	assign ext_flags = ext_link.flags;

	fpic_ext_flags #(.W(fpic_pkg::EXT_W)) u_ext_flags (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.ext(ext_link)
	);

	// Any enabled flag within a module group
	function automatic logic any_pair(input logic [15:0] fl,
		input logic [15:0] en);
		any_pair = |(fl & en);
	endfunction

	always_comb
	begin
		group_hit = '0;
		group_hit[0] = any_pair({4'h0, ext_flags}, {4'h0, ext_enable_r})
			| (I_SUPPLY_MONITOR_REG[fpic_pkg::SUPPLY_EN_BIT]
			& I_SUPPLY_MONITOR_REG[fpic_pkg::SUPPLY_FLAG_BIT]);
		group_hit[1] = (I_SERIAL_MODE_REG[fpic_pkg::SERIAL_EN_BIT]
			& (I_SERIAL_CONTROL_REG[fpic_pkg::SERIAL_RX_BIT]
			| I_SERIAL_CONTROL_REG[fpic_pkg::SERIAL_TX_BIT]))
			| (I_SPI_CONFIG_REG[fpic_pkg::SPI_EN_BIT]
			& (|I_SPI_CONTROL_REG[fpic_pkg::SPI_FLAG_HI:
			fpic_pkg::SPI_FLAG_LO]))
			| any_pair(I_TWOWIRE_STATUS_REG, I_TWOWIRE_IRQ_ENABLE_REG
			& {4'h0, fpic_pkg::TW_SOURCE_MASK});
		group_hit[2] = I_TIMER_B_CONTROL_REG[fpic_pkg::TB_EN_BIT]
			& (I_TIMER_B_CONTROL_REG[fpic_pkg::TB_TRIG_BIT]
			| I_TIMER_B_CONTROL_REG[fpic_pkg::TB_OVF_BIT]);
		group_hit[3] = (I_CONVERTER_CONTROL_REG[fpic_pkg::CONV_EN_BIT]
			& I_CONVERTER_STATUS_REG[fpic_pkg::CONV_FLAG_BIT])
			| (I_AMPLIFIER_CONTROL_REG[fpic_pkg::AMP_EN_BIT]
			& I_AMPLIFIER_CONTROL_REG[fpic_pkg::AMP_FLAG_BIT]);
	end

	assign system_hit = I_WATCHDOG_CONTROL_REG[fpic_pkg::WD_EN_BIT]
		& I_WATCHDOG_CONTROL_REG[fpic_pkg::WD_FLAG_BIT];

	// No ranking among sources: one request line, one vector
	assign pending = global_irq_enable_r & ~in_service_bit_r
		& ((|(group_hit & module_mask_reg_r[3:0]))
		| (system_hit & module_mask_reg_r[fpic_pkg::MASK_SYSTEM_BIT]));

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			irq_req_r <= 1'h0;
		else
			irq_req_r <= pending & ~I_VECTOR_TAKEN;
	end

	// Global enable
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			global_irq_enable_r <= fpic_pkg::GLOBAL_EN_RESET;
		else if (I_CONTROL_WR)
			global_irq_enable_r <=
				I_CONTROL_WDATA[fpic_pkg::CTRL_GLOBAL_EN_BIT];
	end

	// Vectoring wins over return and software so a taken handler is guarded
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			in_service_bit_r <= fpic_pkg::IN_SERVICE_RESET;
		else if (I_VECTOR_TAKEN)
			in_service_bit_r <= 1'h1;
		else if (I_IRQ_RETURN)
			in_service_bit_r <= 1'h0;
		else if (I_CONTROL_WR)
			in_service_bit_r <=
				I_CONTROL_WDATA[fpic_pkg::CTRL_IN_SERVICE_BIT];
	end

	// Module mask
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			module_mask_reg_r <= fpic_pkg::MODULE_MASK_RESET;
		else if (I_MODULE_MASK_WR)
			module_mask_reg_r <= I_MODULE_MASK_WDATA;
	end

	// Handler vector
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			handler_vector_reg_r <= fpic_pkg::VECTOR_RESET;
		else if (I_VECTOR_WR)
			handler_vector_reg_r <= I_VECTOR_WDATA;
	end

	// External local enables
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			ext_enable_r <= fpic_pkg::EXT_RESET;
		else
		begin
			if (I_EXT_ENABLE_LOW_WR)
				ext_enable_r[7:0] <= I_EXT_WDATA;
			if (I_EXT_ENABLE_HIGH_WR)
				ext_enable_r[11:8] <= I_EXT_WDATA[3:0];
		end
	end

	assign O_IRQ_REQ = irq_req_r;
	assign O_HANDLER_VECTOR = handler_vector_reg_r;
	assign O_GLOBAL_ENABLE = global_irq_enable_r;
	assign O_IN_SERVICE = in_service_bit_r;
	assign O_MODULE_MASK = module_mask_reg_r;
	assign O_EXT_ENABLES = ext_enable_r;
	assign O_EXT_FLAGS = ext_flags;

	a_req_needs_global: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		O_IRQ_REQ |-> $past(global_irq_enable_r) && !$past(in_service_bit_r))
		else $error("request without global enable or while in service");

	a_service_blocks_req: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		in_service_bit_r |=> !O_IRQ_REQ)
		else $error("request raised while in service");

	a_taken_sets_service: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		I_VECTOR_TAKEN |=> in_service_bit_r ##1 1'b1)
		else $error("vectoring did not set in-service");

	a_return_clears: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		I_IRQ_RETURN && !I_VECTOR_TAKEN |=> !in_service_bit_r)
		else $error("return did not clear in-service");

	a_mask_blocks_all: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		module_mask_reg_r == 8'h00 |=> !O_IRQ_REQ)
		else $error("request with all modules masked");

	a_vector_stable: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		!I_VECTOR_WR |=> $stable(O_HANDLER_VECTOR))
		else $error("vector changed without a write");

	a_watchdog_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[7] && system_hit |=> O_IRQ_REQ)
		else $error("enabled watchdog source did not request");

	a_ext_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[0] && (|(ext_flags & ext_enable_r))
		|=> O_IRQ_REQ)
		else $error("enabled external source did not request");

	a_timer_gated: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		!module_mask_reg_r[0] && !module_mask_reg_r[1]
		&& !module_mask_reg_r[3] && !module_mask_reg_r[7]
		&& !I_TIMER_B_CONTROL_REG[1] |=> !O_IRQ_REQ)
		else $error("timer request with its enable off");

	a_supply_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[fpic_pkg::MASK_MOD0_BIT]
		&& I_SUPPLY_MONITOR_REG[fpic_pkg::SUPPLY_EN_BIT]
		&& I_SUPPLY_MONITOR_REG[fpic_pkg::SUPPLY_FLAG_BIT] |=> O_IRQ_REQ)
		else $error("enabled supply monitor source did not request");

	a_serial_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[fpic_pkg::MASK_MOD1_BIT]
		&& I_SERIAL_MODE_REG[fpic_pkg::SERIAL_EN_BIT]
		&& (I_SERIAL_CONTROL_REG[fpic_pkg::SERIAL_RX_BIT]
		|| I_SERIAL_CONTROL_REG[fpic_pkg::SERIAL_TX_BIT]) |=> O_IRQ_REQ)
		else $error("enabled serial source did not request");

	a_spi_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[fpic_pkg::MASK_MOD1_BIT]
		&& I_SPI_CONFIG_REG[fpic_pkg::SPI_EN_BIT]
		&& (|I_SPI_CONTROL_REG[fpic_pkg::SPI_FLAG_HI:fpic_pkg::SPI_FLAG_LO])
		|=> O_IRQ_REQ)
		else $error("enabled SPI source did not request");

	a_twowire_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[fpic_pkg::MASK_MOD1_BIT]
		&& (|(I_TWOWIRE_STATUS_REG[11:0] & I_TWOWIRE_IRQ_ENABLE_REG[11:0]
		& fpic_pkg::TW_SOURCE_MASK)) |=> O_IRQ_REQ)
		else $error("enabled two-wire source did not request");

	a_timer_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[fpic_pkg::MASK_MOD2_BIT]
		&& I_TIMER_B_CONTROL_REG[fpic_pkg::TB_EN_BIT]
		&& (I_TIMER_B_CONTROL_REG[fpic_pkg::TB_TRIG_BIT]
		|| I_TIMER_B_CONTROL_REG[fpic_pkg::TB_OVF_BIT]) |=> O_IRQ_REQ)
		else $error("enabled timer source did not request");

	a_converter_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[fpic_pkg::MASK_MOD3_BIT]
		&& I_CONVERTER_CONTROL_REG[fpic_pkg::CONV_EN_BIT]
		&& I_CONVERTER_STATUS_REG[fpic_pkg::CONV_FLAG_BIT] |=> O_IRQ_REQ)
		else $error("enabled converter source did not request");

	a_amp_fires: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		global_irq_enable_r && !in_service_bit_r && !I_VECTOR_TAKEN
		&& module_mask_reg_r[fpic_pkg::MASK_MOD3_BIT]
		&& I_AMPLIFIER_CONTROL_REG[fpic_pkg::AMP_EN_BIT]
		&& I_AMPLIFIER_CONTROL_REG[fpic_pkg::AMP_FLAG_BIT] |=> O_IRQ_REQ)
		else $error("enabled amplifier source did not request");

	a_taken_drops_req: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		I_VECTOR_TAKEN |=> !O_IRQ_REQ)
		else $error("request stood after vectoring");

	a_sw_service_write: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		I_CONTROL_WR && !I_VECTOR_TAKEN && !I_IRQ_RETURN
		|=> in_service_bit_r
		== $past(I_CONTROL_WDATA[fpic_pkg::CTRL_IN_SERVICE_BIT]))
		else $error("software write did not set in-service");

endmodule
